// ===== rtl/led_spi_defines.svh
// constants of the led driver serial register port
// assumes inclusion by the package only
`ifndef LED_SPI_DEFINES_SVH
`define LED_SPI_DEFINES_SVH

`define FRAME_BITS 16
`define CNT_W 4
`define CNT_ONE 4'h1
`define CNT_ZERO 4'h0
`define ADDR_W 7
`define CTRL_DEPTH 32
`define CTRL_IDX_W 5
`define CTRL_LAST 7'h1F

`define A_FUNC_CTRL 7'h00
`define A_GATE_LEVEL 7'h01
`define A_CUR_CH1 7'h02
`define A_CUR_CH2 7'h03
`define A_CUR_CH3 7'h04
`define A_RANGE_SEL 7'h05
`define A_COPY_PULSE 7'h06
`define A_HYST_CH1 7'h0B
`define A_HYST_CH2 7'h0C
`define A_HYST_CH3 7'h0D
`define A_UV_THRESH 7'h0F
`define A_LED_ON_CH1 7'h20
`define A_LED_OFF_CH1 7'h21
`define A_LED_ON_CH2 7'h22
`define A_LED_OFF_CH2 7'h23
`define A_LED_ON_CH3 7'h24
`define A_LED_OFF_CH3 7'h25
`define A_DIE_TEMP 7'h26
`define A_BOOT_FLAGS 7'h34
`define A_HEAD_FLAGS 7'h35
`define A_TOGGLE_FLAGS 7'h36
`define A_PRIMARY 7'h37
`define A_VIN_MEAS 7'h38

`define RST_FUNC_CTRL 8'h0E
`define RST_GATE_LEVEL 8'hFF
`define RST_RANGE_SEL 8'h07
`define RST_HYST 8'h03
`define RST_ZERO 8'h00

`define CLR_ERRORS_BIT 6
`define TOGGLE_FIXED 8'h40
`define TX_ZERO 16'h0000

`endif

// ===== rtl/led_spi_pkg.sv
// types of the led driver serial register port
// assumes led_spi_defines.svh sits beside it
package led_spi_pkg;
`include "led_spi_defines.svh"

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_APPLY = 2'b01,
        ST_REPLY = 2'b10
    } ctl_state_e;

    typedef struct packed {
        logic [`FRAME_BITS-1:0] shreg;
        logic [`CNT_W-1:0] cnt;
        logic tog;
    } link_s;

    typedef struct packed {
        ctl_state_e st;
        logic [`ADDR_W-1:0] addr;
        logic rd;
        logic [7:0] data;
        logic ok;
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic seen_tog;
        logic [2:0] dim_meta;
        logic [2:0] dim_sync;
        logic [2:0] dim_prev;
        logic [2:0] boot;
        logic [2:0] head;
        logic [2:0] reached;
        logic [2:0] toggle;
        logic spi_err;
        logic first;
        logic [7:0] reply;
        logic [`FRAME_BITS-1:0] tx_hold;
        logic [`CTRL_DEPTH-1:0][7:0] ctrl;
    } ctl_s;

endpackage : led_spi_pkg

// ===== rtl/led_spi_port.sv
// serial register port of a three channel led buck driver
// assumes serial_clk idles low and the analog side runs on clk
//
// Notes on behaviour
// - serial output floats while chip select high
// - sample on falling edge, shift on rising
// - byte registers, 7-bit address plus direction bit
// - read frame ignores data, changes nothing
// - reply: primary status, then previous result
// - first frame after off returns zeros
// - frame runs from select low to high
// - multiples of 16 bits pass through chains
// - bad bit count drops write, flags error
// - input voltage register write raises no error
// - 128 registers: control low, diagnostics high
// - diagnostics follow live device values
// - control registers take listed reset values
// - status shifts out while command shifts in
// - read-only access leaves registers intact
// - toggle flags set on edge, clear on write
// - bootstrap flags clear by writing one
`timescale 1ns/1ps
module led_spi_port (
    // system
    input wire logic clk,
    input wire logic reset_n,
    // serial link
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe_n,
    // device mode and pins
    input wire logic device_off,
    input wire logic [2:0] dimming_in,
    // live measurements
    input wire logic [7:0] led_on_voltage_ch1,
    input wire logic [7:0] led_off_voltage_ch1,
    input wire logic [7:0] led_on_voltage_ch2,
    input wire logic [7:0] led_off_voltage_ch2,
    input wire logic [7:0] led_on_voltage_ch3,
    input wire logic [7:0] led_off_voltage_ch3,
    input wire logic [7:0] die_temperature,
    input wire logic [7:0] input_voltage_measurement,
    // flag events and status levels
    input wire logic [2:0] bootstrap_low_evt,
    input wire logic [2:0] low_headroom_evt,
    input wire logic [2:0] current_reached_set,
    input wire logic [2:0] current_reached_clr,
    input wire logic vin_ok,
    input wire logic temp_error,
    input wire logic gate_supply_error,
    input wire logic gate_supply_ok,
    input wire logic [2:0] range_update_req,
    // control register values
    output logic [7:0] function_control,
    output logic [7:0] gate_supply_level,
    output logic [7:0] led_current_ch1,
    output logic [7:0] led_current_ch2,
    output logic [7:0] led_current_ch3,
    output logic [7:0] current_range_select,
    output logic [7:0] reached_flag_copy_pulse,
    output logic [7:0] hysteresis_ch1,
    output logic [7:0] hysteresis_ch2,
    output logic [7:0] hysteresis_ch3,
    output logic [7:0] input_undervoltage_threshold
);
    import led_spi_pkg::*;

    function automatic logic [7:0] ctrl_rst(input logic [`ADDR_W-1:0] a);
        unique case (a)
            `A_FUNC_CTRL: ctrl_rst = `RST_FUNC_CTRL;
            `A_GATE_LEVEL: ctrl_rst = `RST_GATE_LEVEL;
            `A_RANGE_SEL: ctrl_rst = `RST_RANGE_SEL;
            `A_HYST_CH1, `A_HYST_CH2, `A_HYST_CH3: ctrl_rst = `RST_HYST;
            default: ctrl_rst = `RST_ZERO;
        endcase
    endfunction : ctrl_rst

    function automatic logic ctrl_impl(input logic [`ADDR_W-1:0] a);
        unique case (a)
            `A_FUNC_CTRL, `A_GATE_LEVEL, `A_CUR_CH1, `A_CUR_CH2,
            `A_CUR_CH3, `A_RANGE_SEL, `A_COPY_PULSE, `A_HYST_CH1,
            `A_HYST_CH2, `A_HYST_CH3, `A_UV_THRESH: ctrl_impl = 1'b1;
            default: ctrl_impl = 1'b0;
        endcase
    endfunction : ctrl_impl

    function automatic ctl_s ctl_reset();
        ctl_s s;
        s = '0;
        s.st = ST_IDLE;
        s.cs_meta = 1'b1;
        s.cs_sync = 1'b1;
        s.cs_prev = 1'b1;
        for (int i = 0; i < `CTRL_DEPTH; i++) begin
            s.ctrl[i] = ctrl_rst(`ADDR_W'(i));
        end
        ctl_reset = s;
    endfunction : ctl_reset

    localparam ctl_s CTL_RST = ctl_reset();

    ctl_s r;
    ctl_s r_nxt;
    link_s lnk_r;
    link_s lnk_nxt;
    logic fresh_r;
    logic frame_idle;
    logic [7:0] rd_data;
    logic [7:0] status;

    // link side, on the serial clock
    assign frame_idle = chip_select_n | ~reset_n;

    always_comb begin
        lnk_nxt = lnk_r;
        if (fresh_r) begin
            // preload reply word at the first bit of a frame
            lnk_nxt.shreg = {r.tx_hold[`FRAME_BITS-2:0], serial_in};
            lnk_nxt.cnt = `CNT_ONE;
            lnk_nxt.tog = ~lnk_r.tog;
        end else begin
            // older bits fall out the top toward the next device
            lnk_nxt.shreg = {lnk_r.shreg[`FRAME_BITS-2:0], serial_in};
            lnk_nxt.cnt = lnk_r.cnt + `CNT_ONE;
        end
    end

    always_ff @(negedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    always_ff @(negedge serial_clk or posedge frame_idle) begin
        if (frame_idle) begin
            fresh_r <= 1'b1;
        end else begin
            fresh_r <= 1'b0;
        end
    end

    always_ff @(posedge serial_clk or posedge frame_idle) begin
        if (frame_idle) begin
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else begin
            serial_out <= fresh_r ? r.tx_hold[`FRAME_BITS-1]
                                  : lnk_r.shreg[`FRAME_BITS-1];
            serial_out_oe_n <= 1'b0;
        end
    end

    // register file side, on clk
    assign status = {vin_ok, r.spi_err, temp_error, gate_supply_error,
                     gate_supply_ok, range_update_req};

    always_comb begin
        rd_data = `RST_ZERO;
        if (r.addr <= `CTRL_LAST) begin
            rd_data = r.ctrl[r.addr[`CTRL_IDX_W-1:0]];
        end else begin
            unique case (r.addr)
                `A_LED_ON_CH1: rd_data = led_on_voltage_ch1;
                `A_LED_OFF_CH1: rd_data = led_off_voltage_ch1;
                `A_LED_ON_CH2: rd_data = led_on_voltage_ch2;
                `A_LED_OFF_CH2: rd_data = led_off_voltage_ch2;
                `A_LED_ON_CH3: rd_data = led_on_voltage_ch3;
                `A_LED_OFF_CH3: rd_data = led_off_voltage_ch3;
                `A_DIE_TEMP: rd_data = die_temperature;
                `A_BOOT_FLAGS: rd_data = {5'h00, r.boot};
                `A_HEAD_FLAGS: rd_data = {2'h0, r.reached, r.head};
                `A_TOGGLE_FLAGS: rd_data = `TOGGLE_FIXED | {5'h00, r.toggle};
                `A_PRIMARY: rd_data = status;
                `A_VIN_MEAS: rd_data = input_voltage_measurement;
                default: rd_data = `RST_ZERO;
            endcase
        end
    end

    always_comb begin
        logic err_clr;
        logic err_set;
        err_clr = 1'b0;
        err_set = 1'b0;
        r_nxt = r;
        r_nxt.cs_meta = chip_select_n;
        r_nxt.cs_sync = r.cs_meta;
        r_nxt.cs_prev = r.cs_sync;
        r_nxt.dim_meta = dimming_in;
        r_nxt.dim_sync = r.dim_meta;
        r_nxt.dim_prev = r.dim_sync;
        unique case (r.st)
            ST_IDLE: begin
                if (r.cs_sync && !r.cs_prev && lnk_r.tog != r.seen_tog) begin
                    // frame just closed; link words are quiet now
                    r_nxt.seen_tog = lnk_r.tog;
                    r_nxt.rd = lnk_r.shreg[`FRAME_BITS-1];
                    r_nxt.addr = lnk_r.shreg[`FRAME_BITS-2:8];
                    r_nxt.data = lnk_r.shreg[7:0];
                    r_nxt.ok = (lnk_r.cnt == `CNT_ZERO);
                    r_nxt.st = ST_APPLY;
                end
            end
            ST_APPLY: begin
                r_nxt.first = 1'b0;
                if (!r.ok) begin
                    err_set = (r.rd || r.addr != `A_VIN_MEAS);
                    r_nxt.st = ST_IDLE;
                end else begin
                    r_nxt.st = ST_REPLY;
                    if (!r.rd) begin
                        if (r.addr <= `CTRL_LAST && ctrl_impl(r.addr)) begin
                            r_nxt.ctrl[r.addr[`CTRL_IDX_W-1:0]] = r.data;
                        end
                        if (r.addr == `A_FUNC_CTRL) begin
                            err_clr = r.data[`CLR_ERRORS_BIT];
                        end
                        if (r.addr == `A_COPY_PULSE) begin
                            r_nxt.reached = r.reached & ~r.data[2:0];
                        end
                        if (r.addr == `A_BOOT_FLAGS) begin
                            r_nxt.boot = r.boot & ~r.data[2:0];
                        end
                        if (r.addr == `A_HEAD_FLAGS) begin
                            r_nxt.head = 3'h0;
                        end
                        if (r.addr == `A_TOGGLE_FLAGS) begin
                            r_nxt.toggle = 3'h0;
                        end
                    end
                end
            end
            ST_REPLY: begin
                r_nxt.reply = rd_data;
                r_nxt.st = ST_IDLE;
            end
            default: r_nxt.st = ST_IDLE;
        endcase
        // hardware sets win over clears
        r_nxt.reached = (r_nxt.reached & ~current_reached_clr)
                        | current_reached_set;
        r_nxt.boot = r_nxt.boot | bootstrap_low_evt;
        r_nxt.head = r_nxt.head | low_headroom_evt;
        r_nxt.toggle = r_nxt.toggle | (r.dim_sync ^ r.dim_prev);
        r_nxt.spi_err = (r.spi_err & ~err_clr) | err_set;
        if (device_off) begin
            r_nxt.first = 1'b1;
        end
        // reply word frozen while a frame runs
        if (r.cs_sync) begin
            r_nxt.tx_hold = r.first ? `TX_ZERO : {status, r.reply};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= CTL_RST;
        end else begin
            r <= r_nxt;
        end
    end

    assign function_control = r.ctrl[`A_FUNC_CTRL];
    assign gate_supply_level = r.ctrl[`A_GATE_LEVEL];
    assign led_current_ch1 = r.ctrl[`A_CUR_CH1];
    assign led_current_ch2 = r.ctrl[`A_CUR_CH2];
    assign led_current_ch3 = r.ctrl[`A_CUR_CH3];
    assign current_range_select = r.ctrl[`A_RANGE_SEL];
    assign reached_flag_copy_pulse = r.ctrl[`A_COPY_PULSE];
    assign hysteresis_ch1 = r.ctrl[`A_HYST_CH1];
    assign hysteresis_ch2 = r.ctrl[`A_HYST_CH2];
    assign hysteresis_ch3 = r.ctrl[`A_HYST_CH3];
    assign input_undervoltage_threshold = r.ctrl[`A_UV_THRESH];

    a_write_lands: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == ST_APPLY && r.ok && !r.rd && r.addr == `A_GATE_LEVEL)
        |=> r.ctrl[`A_GATE_LEVEL] == $past(r.data))
        else $error("write did not reach gate level register");

    a_read_keeps_regs: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == ST_APPLY && r.rd) |=> r.ctrl == $past(r.ctrl))
        else $error("read frame changed control registers");

    a_bad_no_write: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == ST_APPLY && !r.ok) |=> r.ctrl == $past(r.ctrl) && (r.spi_err
            || ($past(r.addr) == `A_VIN_MEAS && !$past(r.rd))))
        else $error("bad length frame wrote or left no error");

    a_vin_no_error: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == ST_APPLY && !r.rd && r.addr == `A_VIN_MEAS && !r.spi_err)
        |=> !r.spi_err)
        else $error("write to input voltage register set error");

    a_reply_capture: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == ST_APPLY && r.ok) |=> ##1 r.reply == $past(rd_data))
        else $error("reply byte not taken from addressed register");

    a_first_zero: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.first && r.cs_sync) |=> r.tx_hold == `TX_ZERO)
        else $error("first frame after off mode not zero");

    a_status_top: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!r.first && r.cs_sync) |=> r.tx_hold[`FRAME_BITS-1:8] == $past(status))
        else $error("reply upper byte is not primary status");

    a_toggle_sets: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.dim_sync != r.dim_prev)
        |=> (r.toggle & $past(r.dim_sync ^ r.dim_prev))
            == $past(r.dim_sync ^ r.dim_prev))
        else $error("dimming edge did not set toggle flag");

    a_boot_w1c: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == ST_APPLY && r.ok && !r.rd && r.addr == `A_BOOT_FLAGS
         && bootstrap_low_evt == 3'h0)
        |=> r.boot == ($past(r.boot) & ~$past(r.data[2:0])))
        else $error("bootstrap flags not cleared by writing one");

    a_float_idle: assert property (
        @(posedge clk) disable iff (!reset_n)
        chip_select_n |-> serial_out_oe_n)
        else $error("serial output driven while deselected");

    a_regs_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st != ST_APPLY) |=> r.ctrl == $past(r.ctrl))
        else $error("control register changed outside a write");

    a_reply_frozen: assert property (
        @(posedge clk) disable iff (!reset_n)
        !r.cs_sync |=> r.tx_hold == $past(r.tx_hold))
        else $error("reply word changed during a frame");

    a_bad_no_reply: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == ST_APPLY && !r.ok)
        |=> r.st == ST_IDLE && r.reply == $past(r.reply))
        else $error("bad length frame updated the reply byte");

    a_err_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == ST_APPLY && r.ok && !r.rd && r.addr == `A_FUNC_CTRL
         && r.data[`CLR_ERRORS_BIT]) |=> !r.spi_err)
        else $error("clear errors write left the serial error flag");

    a_toggle_clears: assert property (
        @(posedge clk) disable iff (!reset_n)
        (r.st == ST_APPLY && r.ok && !r.rd && r.addr == `A_TOGGLE_FLAGS
         && r.dim_sync == r.dim_prev) |=> r.toggle == 3'h0)
        else $error("write to toggle flags did not clear them");

    a_boot_set_wins: assert property (
        @(posedge clk) disable iff (!reset_n)
        (bootstrap_low_evt != 3'h0)
        |=> (r.boot & $past(bootstrap_low_evt)) == $past(bootstrap_low_evt))
        else $error("bootstrap event did not set its flag");

    a_first_off: assert property (
        @(posedge clk) disable iff (!reset_n)
        device_off |=> r.first)
        else $error("off mode did not arm the zero reply");

endmodule : led_spi_port

// ===== testbench/spi_master_model.sv
// serial master model driving the port's link, one frame per call
// assumes 160 ns serial clock periods and a device that drives serial_out
`timescale 1ns/1ps
module spi_master_model (
    // link to the device
    output logic serial_clk,
    output logic chip_select_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);
    localparam real HALF = 80.0;

    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b1;
        serial_in = 1'b0;
    end

    // shifts n bits of tx msb first, collects n bits of serial_out
    task automatic xfer(input int n, input logic [31:0] tx,
                        output logic [31:0] rx, output logic oe_bad);
        int i;
        rx = '0;
        oe_bad = serial_out_oe_n !== 1'b1;
        #3.1 chip_select_n = 1'b0;
        #HALF;
        for (i = n - 1; i >= 0; i--) begin
            serial_clk = 1'b1;
            serial_in = tx[i];
            #HALF;
            oe_bad |= serial_out_oe_n !== 1'b0;
            rx = {rx[30:0], serial_out};
            serial_clk = 1'b0;
            #HALF;
        end
        chip_select_n = 1'b1;
        serial_in = ~serial_in;
        #1 oe_bad |= serial_out_oe_n !== 1'b1;
        #300;
    endtask : xfer
endmodule : spi_master_model

// ===== testbench/led_driver_spi_register_port_tb.sv
// self-checking bench of the led driver serial register port
// assumes spi_master_model on the link and a 100 MHz system clock
`timescale 1ns/1ps
module led_driver_spi_register_port_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic device_off = 1'b1;
    logic [2:0] dimming_in = 3'h0;
    logic [2:0] boot_evt = 3'h0;
    logic [2:0] range_req = 3'h0;
    logic [3:0] lv = 4'h0;
    logic [7:0] live [8];
    wire [7:0] ctl_o [11];
    wire serial_clk, chip_select_n, serial_in, serial_out, serial_out_oe_n;
    int fail_count = 0;
    int check_count = 0;
    int seed = 32'h68344202;
    int caddr [11] = '{0, 1, 2, 3, 4, 5, 6, 11, 12, 13, 15};
    logic [7:0] ctl_m [32];
    logic [7:0] rep_m = 8'h00;
    logic err_m = 1'b0;
    logic first_m = 1'b1;
    logic [2:0] boot_m = 3'h0;
    logic [2:0] tog_m = 3'h0;

    always #5 clk = ~clk;

    spi_master_model spi_master_model_i (.serial_clk(serial_clk),
        .chip_select_n(chip_select_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

    led_spi_port led_spi_port_i (.clk(clk), .reset_n(reset_n),
        .serial_clk(serial_clk), .chip_select_n(chip_select_n),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .device_off(device_off),
        .dimming_in(dimming_in), .led_on_voltage_ch1(live[0]),
        .led_off_voltage_ch1(live[1]), .led_on_voltage_ch2(live[2]),
        .led_off_voltage_ch2(live[3]), .led_on_voltage_ch3(live[4]),
        .led_off_voltage_ch3(live[5]), .die_temperature(live[6]),
        .input_voltage_measurement(live[7]), .bootstrap_low_evt(boot_evt),
        .low_headroom_evt(3'h0), .current_reached_set(3'h0),
        .current_reached_clr(3'h0), .vin_ok(lv[3]), .temp_error(lv[2]),
        .gate_supply_error(lv[1]), .gate_supply_ok(lv[0]),
        .range_update_req(range_req), .function_control(ctl_o[0]),
        .gate_supply_level(ctl_o[1]), .led_current_ch1(ctl_o[2]),
        .led_current_ch2(ctl_o[3]), .led_current_ch3(ctl_o[4]),
        .current_range_select(ctl_o[5]),
        .reached_flag_copy_pulse(ctl_o[6]), .hysteresis_ch1(ctl_o[7]),
        .hysteresis_ch2(ctl_o[8]), .hysteresis_ch3(ctl_o[9]),
        .input_undervoltage_threshold(ctl_o[10]));

    task automatic test_done;
        if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    function automatic logic [7:0] rst_of(int a);
        case (a)
            0: return 8'h0E;
            1: return 8'hFF;
            5: return 8'h07;
            11, 12, 13: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction : rst_of

    function automatic bit is_impl(logic [6:0] a);
        foreach (caddr[i]) if (a == 7'(caddr[i])) return 1'b1;
        return 1'b0;
    endfunction : is_impl

    function automatic logic [7:0] status();
        return {lv[3], err_m, lv[2], lv[1], lv[0], range_req};
    endfunction : status

    function automatic logic [7:0] reg_m(logic [6:0] a);
        if (a < 7'h20) return is_impl(a) ? ctl_m[a] : 8'h00;
        if (a <= 7'h26) return live[a - 7'h20];
        case (a)
            7'h34: return {5'h00, boot_m};
            7'h36: return {5'h08, tog_m};
            7'h37: return status();
            7'h38: return live[7];
            default: return 8'h00;
        endcase
    endfunction : reg_m

    task automatic chk_ctl;
        foreach (ctl_o[i]) begin
            check("control", {8'h00, ctl_o[i]}, {8'h00, ctl_m[caddr[i]]});
        end
    endtask : chk_ctl

    // one frame of n bits; the device acts on the last 16 of tx
    task automatic frame(input int n, input logic [31:0] tx);
        logic [31:0] rx;
        logic [31:0] sh;
        logic oe_bad;
        logic [15:0] exp16;
        logic [6:0] a;
        a = tx[14:8];
        exp16 = first_m ? 16'h0000 : {status(), rep_m};
        spi_master_model_i.xfer(n, tx, rx, oe_bad);
        sh = rx >> (n - 16);
        check("oe_n", {15'h0000, oe_bad}, 16'h0000);
        check("reply hi", {8'h00, sh[15:8]}, {8'h00, exp16[15:8]});
        check("reply lo", 16'(sh[7:0]), 16'(exp16[7:0]));
        if (n == 32) check("chain", rx[15:0], tx[31:16]);
        first_m = 1'b0;
        if (n % 16 != 0) begin
            if (tx[15] || a != 7'h38) err_m = 1'b1;
        end else if (tx[15]) begin
            rep_m = reg_m(a);
        end else begin
            if (a < 7'h20 && is_impl(a)) ctl_m[a] = tx[7:0];
            if (a == 7'h00 && tx[6]) begin
                err_m = 1'b0;
            end
            if (a == 7'h34) boot_m &= ~tx[2:0];
            if (a == 7'h36) tog_m = 3'h0;
            rep_m = reg_m(a);
        end
    endtask : frame

    task automatic shake;
        int i;
        @(posedge clk);
        lv <= 4'($random(seed));
        range_req <= 3'($random(seed));
        for (i = 0; i < 8; i++) live[i] <= 8'($random(seed));
        repeat (3) @(posedge clk);
    endtask : shake

    initial begin
        #500000;
        fail_count++;
        test_done();
    end

    initial begin
        int i;
        logic [6:0] a;
        for (i = 0; i < 8; i++) live[i] = 8'h00;
        for (i = 0; i < 32; i++) ctl_m[i] = rst_of(i);
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        device_off <= 1'b0;
        repeat (3) @(posedge clk);
        chk_ctl();
        frame(16, 32'h0000B700);
        for (i = 0; i < 12; i++) begin
            shake();
            a = 7'(1 + {$random(seed)} % 31);
            frame(16, {17'h00000, a, 8'($random(seed))});
        end
        chk_ctl();
        for (i = 0; i < 8; i++) begin
            a = 7'({$random(seed)} % 32);
            frame(16, {16'h0000, 1'b1, a, 8'($random(seed))});
        end
        chk_ctl();
        shake();
        for (i = 0; i < 8; i++) begin
            a = (i < 7) ? 7'(32 + i) : 7'h38;
            frame(16, {16'h0000, 1'b1, a, 8'h5A});
        end
        frame(17, 32'h000138A5);
        frame(16, 32'h000038A5);
        frame(17, 32'h00010277);
        chk_ctl();
        frame(16, 32'h0000B700);
        frame(16, 32'h0000004E);
        frame(16, 32'h0000000E);
        frame(32, 32'h850003C3);
        chk_ctl();
        @(posedge clk);
        dimming_in <= 3'h5;
        repeat (6) @(posedge clk);
        tog_m = 3'h5;
        frame(16, 32'h0000B600);
        frame(16, 32'h00003600);
        frame(16, 32'h0000B600);
        @(posedge clk);
        boot_evt <= 3'h7;
        @(posedge clk);
        boot_evt <= 3'h0;
        repeat (4) @(posedge clk);
        boot_m = 3'h7;
        frame(16, 32'h0000B400);
        frame(16, 32'h00003405);
        frame(16, 32'h0000B400);
        frame(16, 32'h0000B700);
        chk_ctl();
        test_done();
    end
endmodule : led_driver_spi_register_port_tb
